// File: verilog/sff_spi_front.v
// Serial flash SPI front end: link sampling, command decode, protection, status
`timescale 1ns/1ps
`default_nettype none
`include "sff_map.vh"

// Overview of operation
// - Chip select low enables the logic and lets transfers proceed.
// - Chip select high deselects the device and shows standby.
// - While deselected, serial input is ignored and outputs are not driven.
// - With protect pin low, protect-level bits decide which locations may change.
// - With protect pin high, protect-level bits only block whole-array erase.
// - Pause input freezes the transfer; it resumes at the same bit.
// - Every input bit is sampled on a rising serial clock edge.
// - Output data changes on the falling serial clock edge.
// - Page program takes one to 256 bytes as one operation.
// - Array splits into 4 KByte sectors and 64 KByte blocks.
// - Byte array of 256K or 512K locations sets address width.
// - Dual-output fast read drives two bits per clock on both lines.
// - With protect pin low, protect-level bits mark part or all of the array read-only.
// - Busy flag at status bit 0 is 1 during program or erase.
// - Write-enable latch at bit 1 needed before writes; cleared on completion.
// - Status lock bit 7 with protect pin low blocks status writes.
// - Whole-array erase only runs when all protect-level bits are zero.
module sff_spi_front #(
  parameter ADDR_W = `SFF_ADDR_W_LARGE
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire reset_i,
  // Serial link pins
  input wire cs_n_i,
  input wire sck_i,
  input wire bidir_serial_line_i,
  output reg bidir_serial_line_o,
  output wire bidir_serial_line_oe_o,
  output reg so_o,
  output wire so_oe_o,
  input wire write_protect_n_i,
  input wire pause_n_i,
  // Status view
  output reg standby_o,
  output wire [7:0] status_o,
  output reg overrun_o,
  // Array read port
  output wire [ADDR_W-1:0] rd_addr_o,
  input wire [7:0] rd_data_i,
  // Program data stream
  output wire prog_valid_o,
  input wire prog_ready_i,
  output wire [ADDR_W-1:0] prog_addr_o,
  output wire [7:0] prog_data_o,
  output reg prog_commit_o,
  // Erase request and completion
  output reg erase_req_o,
  output reg [1:0] erase_kind_o,
  output reg [ADDR_W-1:0] erase_addr_o,
  input wire op_done_i
);

  localparam integer NBLK = 1 << (ADDR_W - `SFF_BLOCK_BITS);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_CMD = 3'd1;
  localparam [2:0] ST_ADDR = 3'd2;
  localparam [2:0] ST_DUMMY = 3'd3;
  localparam [2:0] ST_RDATA = 3'd4;
  localparam [2:0] ST_STAT = 3'd5;
  localparam [2:0] ST_WSR = 3'd6;
  localparam [2:0] ST_PDATA = 3'd7;

  // Upper blocks protected; level L covers 2^(L-1) blocks, clipped to all
  function prot_hit;
    input [ADDR_W-1:0] a;
    input [2:0] lvl;
    input wpn;
    integer nprot;
    integer blk;
    begin
      nprot = (lvl == 3'd0) ? 0 : (1 << (lvl - 3'd1));
      if (nprot > NBLK) nprot = NBLK;
      blk = a[ADDR_W-1:`SFF_BLOCK_BITS];
      prot_hit = ~wpn & (lvl != 3'd0) & (blk >= NBLK - nprot);
    end
  endfunction

  // Synchronisers; stage 1 feeds stage 2 only
  reg cs_s1, cs_s2, cs_q;
  reg sck_s1, sck_s2, sck_q;
  reg sio_s1, sio_s2;
  reg hold_s1, hold_s2;
  reg wp_s1, wp_s2;

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_q <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_q <= 1'b0;
      sio_s1 <= 1'b0;
      sio_s2 <= 1'b0;
      hold_s1 <= 1'b1;
      hold_s2 <= 1'b1;
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
    end else begin
      cs_s1 <= cs_n_i;
      cs_s2 <= cs_s1;
      cs_q <= cs_s2;
      sck_s1 <= sck_i;
      sck_s2 <= sck_s1;
      sck_q <= sck_s2;
      sio_s1 <= bidir_serial_line_i;
      sio_s2 <= sio_s1;
      hold_s1 <= pause_n_i;
      hold_s2 <= hold_s1;
      wp_s1 <= write_protect_n_i;
      wp_s2 <= wp_s1;
    end
  end

  // Edges are swallowed while paused, so the bit position is kept
  wire live = ~cs_s2 & hold_s2;
  wire sck_rise = live & sck_s2 & ~sck_q;
  wire sck_fall = live & ~sck_s2 & sck_q;
  wire cs_fall = cs_q & ~cs_s2;
  wire cs_rise = ~cs_q & cs_s2;

  reg [2:0] state;
  reg [7:0] cmd;
  reg [6:0] in_sh;
  reg [2:0] in_cnt;
  reg [1:0] addr_cnt;
  reg [15:0] addr_sh;
  reg [ADDR_W-1:0] addr;
  reg [7:0] out_sh;
  reg [2:0] out_cnt;
  reg so_drv, sio_drv;
  reg pend;
  reg [8:0] pcount;
  reg [7:0] wsr_byte;
  reg busy, write_enable_latch_flag, lock;
  reg [2:0] bp;

  wire [7:0] in_byte = {in_sh, sio_s2};
  wire [23:0] addr_full = {addr_sh, in_byte};
  wire dual = (cmd == `SFF_OP_DUAL_READ);
  wire stat_rd = (state == ST_STAT);
  wire is_out = (state == ST_RDATA) | stat_rd;
  wire [7:0] cur_byte = (out_cnt != 3'd0) ? out_sh : (stat_rd ? status_o : rd_data_i);
  wire [ADDR_W-1:0] page_addr = {addr[ADDR_W-1:8], pcount[7:0]};
  wire page_ok = write_enable_latch_flag & ~prot_hit(addr, bp, wp_s2) & (pcount < `SFF_PAGE_BYTES);
  wire lock_act = lock & ~wp_s2;

  // Program byte stream into the two-entry buffer
  wire buf_in_ready;
  wire push = sck_rise & (in_cnt == 3'd7) & (state == ST_PDATA) & page_ok;

  assign status_o = {lock, 2'b00, bp, write_enable_latch_flag, busy};
  assign rd_addr_o = addr;
  assign so_oe_o = so_drv & live;
  assign bidir_serial_line_oe_o = sio_drv & live;

  sff_pair_buf #(
    .W(ADDR_W + 8)
  ) u_buf (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .in_valid_i(push),
    .in_ready_o(buf_in_ready),
    .in_data_i({page_addr, in_byte}),
    .out_valid_o(prog_valid_o),
    .out_ready_i(prog_ready_i),
    .out_data_o({prog_addr_o, prog_data_o})
  );

  // Transfer sequencer, status bits and operation launch
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
      cmd <= 8'h00;
      in_sh <= 7'h00;
      in_cnt <= 3'd0;
      addr_cnt <= 2'd0;
      addr_sh <= 16'h0000;
      addr <= {ADDR_W{1'b0}};
      out_sh <= 8'h00;
      out_cnt <= 3'd0;
      so_drv <= 1'b0;
      sio_drv <= 1'b0;
      so_o <= 1'b0;
      bidir_serial_line_o <= 1'b0;
      pend <= 1'b0;
      pcount <= 9'd0;
      wsr_byte <= 8'h00;
      busy <= 1'b0;
      write_enable_latch_flag <= 1'b0;
      lock <= 1'b0;
      bp <= 3'd0;
      standby_o <= 1'b1;
      overrun_o <= 1'b0;
      prog_commit_o <= 1'b0;
      erase_req_o <= 1'b0;
      erase_kind_o <= `SFF_ERASE_SECTOR;
      erase_addr_o <= {ADDR_W{1'b0}};
    end else begin
      prog_commit_o <= 1'b0;
      erase_req_o <= 1'b0;
      standby_o <= cs_s2;
      // Completion frees the array and drops the latch
      if (op_done_i) begin
        busy <= 1'b0;
        write_enable_latch_flag <= 1'b0;
      end
      if (cs_fall) begin
        state <= ST_CMD;
        in_cnt <= 3'd0;
        out_cnt <= 3'd0;
        addr_cnt <= 2'd0;
        pcount <= 9'd0;
        pend <= 1'b0;
        overrun_o <= 1'b0;
      end
      if (cs_rise) begin
        state <= ST_IDLE;
        so_drv <= 1'b0;
        sio_drv <= 1'b0;
        // Launch only on a whole-byte boundary
        if (pend & (in_cnt == 3'd0)) begin
          case (cmd)
            `SFF_OP_STATUS_WRITE: begin
              if (write_enable_latch_flag & ~lock_act) begin
                bp <= wsr_byte[`SFF_ST_BP_HI:`SFF_ST_BP_LO];
                lock <= wsr_byte[`SFF_ST_LOCK];
                write_enable_latch_flag <= 1'b0;
              end
            end
            `SFF_OP_PAGE_PROG: begin
              prog_commit_o <= 1'b1;
              busy <= 1'b1;
            end
            `SFF_OP_SECTOR_ERASE, `SFF_OP_BLOCK_ERASE: begin
              if (write_enable_latch_flag & ~prot_hit(addr, bp, wp_s2)) begin
                erase_req_o <= 1'b1;
                erase_kind_o <= (cmd == `SFF_OP_BLOCK_ERASE) ? `SFF_ERASE_BLOCK : `SFF_ERASE_SECTOR;
                erase_addr_o <= addr;
                busy <= 1'b1;
              end
            end
            `SFF_OP_WHOLE_ERASE: begin
              if (write_enable_latch_flag & (bp == 3'd0)) begin
                erase_req_o <= 1'b1;
                erase_kind_o <= `SFF_ERASE_WHOLE;
                erase_addr_o <= {ADDR_W{1'b0}};
                busy <= 1'b1;
              end
            end
            default: begin
              pend <= 1'b0;
            end
          endcase
        end
      end
      // Input side: shift on rising edge, act per whole byte
      if (sck_rise & (state != ST_IDLE)) begin
        in_sh <= in_byte[6:0];
        in_cnt <= in_cnt + 3'd1;
        if (in_cnt == 3'd7) begin
          case (state)
            ST_CMD: begin
              cmd <= in_byte;
              state <= ST_IDLE;
              // While busy only the status read is honoured
              if (in_byte == `SFF_OP_STATUS_READ) begin
                state <= ST_STAT;
              end else if (~busy) begin
                case (in_byte)
                  `SFF_OP_SET_SET_WRITE_ENABLE_CMD: write_enable_latch_flag <= 1'b1;
                  `SFF_OP_WRITE_DIS: write_enable_latch_flag <= 1'b0;
                  `SFF_OP_STATUS_WRITE: state <= ST_WSR;
                  `SFF_OP_WHOLE_ERASE: pend <= 1'b1;
                  `SFF_OP_READ, `SFF_OP_FAST_READ, `SFF_OP_DUAL_READ, `SFF_OP_PAGE_PROG,
                  `SFF_OP_SECTOR_ERASE, `SFF_OP_BLOCK_ERASE: state <= ST_ADDR;
                  default: state <= ST_IDLE;
                endcase
              end
            end
            ST_ADDR: begin
              addr_sh <= {addr_sh[7:0], in_byte};
              addr_cnt <= addr_cnt + 2'd1;
              if (addr_cnt == `SFF_ADDR_BYTES - 2'd1) begin
                addr <= addr_full[ADDR_W-1:0];
                case (cmd)
                  `SFF_OP_READ: state <= ST_RDATA;
                  `SFF_OP_FAST_READ, `SFF_OP_DUAL_READ: state <= ST_DUMMY;
                  `SFF_OP_PAGE_PROG: state <= ST_PDATA;
                  default: begin
                    state <= ST_IDLE;
                    pend <= 1'b1;
                  end
                endcase
              end
            end
            ST_DUMMY: state <= ST_RDATA;
            ST_WSR: begin
              wsr_byte <= in_byte;
              pend <= 1'b1;
              state <= ST_IDLE;
            end
            ST_PDATA: begin
              // Bytes past a full page are dropped, not wrapped
              if (page_ok) begin
                pcount <= pcount + 9'd1;
                pend <= 1'b1;
              end
            end
            default: state <= state;
          endcase
        end
      end
      // Receiver stall beyond two bytes loses data; flag it
      if (push & ~buf_in_ready) overrun_o <= 1'b1;
      // Output side: update on falling edge, one or two bits per clock
      if (sck_fall & is_out) begin
        so_drv <= 1'b1;
        sio_drv <= dual & ~stat_rd;
        if (dual & ~stat_rd) begin
          bidir_serial_line_o <= cur_byte[7];
          so_o <= cur_byte[6];
          out_sh <= {cur_byte[5:0], 2'b00};
          out_cnt <= out_cnt + 3'd2;
        end else begin
          so_o <= cur_byte[7];
          out_sh <= {cur_byte[6:0], 1'b0};
          out_cnt <= out_cnt + 3'd1;
        end
        if ((out_cnt == 3'd0) & ~stat_rd) addr <= addr + {{(ADDR_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // sff_spi_front

`default_nettype wire

// File: verilog/sff_map.vh
// Constants for the serial flash front end: opcodes, status bits, geometry
`ifndef SFF_MAP_VH
`define SFF_MAP_VH

// Array geometry
`define SFF_ADDR_W_SMALL 18
`define SFF_ADDR_W_LARGE 19
`define SFF_SECTOR_BITS 12
`define SFF_BLOCK_BITS 16
`define SFF_PAGE_BYTES 256
`define SFF_ADDR_BYTES 2'd3

// Instruction codes
`define SFF_OP_STATUS_WRITE 8'h01
`define SFF_OP_PAGE_PROG 8'h02
`define SFF_OP_READ 8'h03
`define SFF_OP_WRITE_DIS 8'h04
`define SFF_OP_STATUS_READ 8'h05
`define SFF_OP_SET_SET_WRITE_ENABLE_CMD 8'h06
`define SFF_OP_FAST_READ 8'h0b
`define SFF_OP_SECTOR_ERASE 8'h20
`define SFF_OP_DUAL_READ 8'h3b
`define SFF_OP_WHOLE_ERASE 8'hc7
`define SFF_OP_BLOCK_ERASE 8'hd8

// Status register layout
`define SFF_ST_BUSY 0
`define SFF_ST_WEL 1
`define SFF_ST_BP_LO 2
`define SFF_ST_BP_HI 4
`define SFF_ST_LOCK 7
`define SFF_STATUS_RESET 8'h00

// Erase kinds
`define SFF_ERASE_SECTOR 2'd0
`define SFF_ERASE_BLOCK 2'd1
`define SFF_ERASE_WHOLE 2'd2

`endif

// File: verilog/sff_pair_buf.v
// Two-entry valid/ready buffer for program data words
`timescale 1ns/1ps
`default_nettype none

module sff_pair_buf #(
  parameter W = 8
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire reset_i,
  // Filling side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  // Draining side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o
);

  reg [W-1:0] slot0;
  reg [W-1:0] slot1;
  reg [1:0] fill;

  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  // No pass-through when full: keeps ready free of a path from the drain
  assign in_ready_o = (fill != 2'd2);
  assign out_valid_o = (fill != 2'd0);
  assign out_data_o = slot0;

  // Slot 0 is always the head
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      fill <= 2'd0;
      slot0 <= {W{1'b0}};
      slot1 <= {W{1'b0}};
    end else begin
      case ({push, pop})
        2'b10: begin
          if (fill == 2'd0) slot0 <= in_data_i;
          else slot1 <= in_data_i;
          fill <= fill + 2'd1;
        end
        2'b01: begin
          slot0 <= slot1;
          fill <= fill - 2'd1;
        end
        2'b11: begin
          if (fill == 2'd1) begin
            slot0 <= in_data_i;
          end else begin
            slot0 <= slot1;
            slot1 <= in_data_i;
          end
        end
        default: begin
          fill <= fill;
        end
      endcase
    end
  end

endmodule // sff_pair_buf

`default_nettype wire

// File: testbench/sff_front_sva.sv
// Port checker for the serial flash front end
`timescale 1ns/1ps
`default_nettype none
module sff_front_sva #(parameter ADDR_W = 19) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Link pins
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic pause_n_i,
  input wire logic so_o,
  input wire logic so_oe_o,
  input wire logic bidir_serial_line_oe_o,
  // Status and array side
  input wire logic standby_o,
  input wire logic [7:0] status_o,
  input wire logic prog_valid_o,
  input wire logic prog_ready_i,
  input wire logic [ADDR_W-1:0] prog_addr_o,
  input wire logic [7:0] prog_data_o,
  input wire logic prog_commit_o,
  input wire logic erase_req_o,
  input wire logic [1:0] erase_kind_o,
  input wire logic op_done_i
);
  logic sck_q;
  logic [4:0] fell_q;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Recent clock falls; outputs may only move shortly after one
  always @(posedge sys_clk_i) begin
    sck_q <= sck_i;
    fell_q <= {fell_q[3:0], sck_q & ~sck_i};
  end
  sel_wake_a: assert property ((!cs_n_i) [*4] |=> !standby_o)
    else $error("standby while selected");
  desel_stby_a: assert property (cs_n_i [*4] |=> standby_o)
    else $error("no standby when deselected");
  desel_quiet_a: assert property (cs_n_i [*3] |=> !so_oe_o && !bidir_serial_line_oe_o)
    else $error("outputs driven while deselected");
  pause_quiet_a: assert property ((!pause_n_i) [*3] |=> !so_oe_o && !bidir_serial_line_oe_o)
    else $error("outputs driven while paused");
  out_on_fall_a: assert property (so_oe_o && $past(so_oe_o) && $changed(so_o) |-> fell_q[4:1] != 4'h0)
    else $error("output moved without a clock fall");
  commit_busy_a: assert property (prog_commit_o |=> status_o[0])
    else $error("busy not set by commit");
  done_clear_a: assert property (op_done_i && status_o[0] |=> !status_o[0] && !status_o[1])
    else $error("busy or latch kept after completion");
  wel_first_a: assert property (erase_req_o || prog_valid_o |-> status_o[1])
    else $error("write without latch");
  whole_guard_a: assert property (erase_req_o && erase_kind_o == 2'd2 |-> status_o[4:2] == 3'b000)
    else $error("whole erase with protection set");
  prog_hold_a: assert property (prog_valid_o && !prog_ready_i |=> prog_valid_o && $stable(prog_data_o))
    else $error("program word dropped while stalled");
  c_commit: cover property (prog_commit_o);
  c_erase: cover property (erase_req_o);
  c_dual: cover property (bidir_serial_line_oe_o && so_oe_o);
endmodule // sff_front_sva
bind sff_spi_front sff_front_sva #(.ADDR_W(ADDR_W)) u_sva (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
  .cs_n_i(cs_n_i), .sck_i(sck_i), .pause_n_i(pause_n_i), .so_o(so_o), .so_oe_o(so_oe_o),
  .bidir_serial_line_oe_o(bidir_serial_line_oe_o), .standby_o(standby_o), .status_o(status_o),
  .prog_valid_o(prog_valid_o), .prog_ready_i(prog_ready_i), .prog_addr_o(prog_addr_o), .prog_data_o(prog_data_o),
  .prog_commit_o(prog_commit_o), .erase_req_o(erase_req_o), .erase_kind_o(erase_kind_o), .op_done_i(op_done_i));
`default_nettype wire

// File: testbench/sff_array_model.sv
// Array-side model: read data, program drain, completion pulse
`timescale 1ns/1ps
`default_nettype none
module sff_array_model #(parameter ADDR_W = 19, parameter DONE_CYC = 40) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Bench control
  input wire logic stall_i,
  // Read port
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  // Program stream and operations
  input wire logic prog_valid_i,
  output logic prog_ready_o,
  input wire logic prog_commit_i,
  input wire logic erase_req_i,
  output logic op_done_o
);
  logic pend;
  logic [7:0] cnt;
  // Data lags the address a cycle, stale byte shown meanwhile
  always @(posedge sys_clk_i) begin
    rd_data_o <= rd_addr_i[7:0] ^ 8'ha5;
  end
  assign prog_ready_o = !stall_i;
  // Completion only once the buffer has drained
  always @(posedge sys_clk_i) begin
    op_done_o <= 1'b0;
    if (reset_i) begin
      pend <= 1'b0;
    end else if (prog_commit_i || erase_req_i) begin
      pend <= 1'b1;
      cnt <= 8'h00;
    end else if (pend && !prog_valid_i) begin
      cnt <= cnt + 8'h01;
      if (cnt == DONE_CYC) begin
        pend <= 1'b0;
        op_done_o <= 1'b1;
      end
    end
  end
endmodule // sff_array_model
`default_nettype wire

// File: testbench/tb_top.sv
// Bench for the serial flash front end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0, reset = 1'b1, cs_n = 1'b1, sck = 1'b0, sdi = 1'b0, wp_n = 1'b1, pause_n = 1'b1;
  logic stall = 1'b0, idle_hi = 1'b0;
  logic sio_o, sio_oe, so, so_oe, standby, overrun, prog_valid, prog_ready, prog_commit, erase_req, op_done;
  logic [7:0] status, rd_data, prog_data, first_data, rx;
  logic [18:0] rd_addr, prog_addr, erase_addr, first_addr, er_addr;
  logic [1:0] erase_kind, er_kind;
  logic [15:0] dl;
  int bad_count = 0, cmp_count = 0, push_n = 0, er_n = 0;
  wire sio_w = sio_oe ? sio_o : sdi;
  always #4 sys_clk = ~sys_clk;
  sff_spi_front #(.ADDR_W(19)) dut (.sys_clk_i(sys_clk), .reset_i(reset), .cs_n_i(cs_n), .sck_i(sck),
    .bidir_serial_line_i(sio_w), .bidir_serial_line_o(sio_o), .bidir_serial_line_oe_o(sio_oe), .so_o(so),
    .so_oe_o(so_oe), .write_protect_n_i(wp_n), .pause_n_i(pause_n), .standby_o(standby), .status_o(status),
    .overrun_o(overrun), .rd_addr_o(rd_addr), .rd_data_i(rd_data), .prog_valid_o(prog_valid),
    .prog_ready_i(prog_ready), .prog_addr_o(prog_addr), .prog_data_o(prog_data), .prog_commit_o(prog_commit),
    .erase_req_o(erase_req), .erase_kind_o(erase_kind), .erase_addr_o(erase_addr), .op_done_i(op_done));
  sff_array_model #(.ADDR_W(19)) u_arr (.sys_clk_i(sys_clk), .reset_i(reset), .stall_i(stall),
    .rd_addr_i(rd_addr), .rd_data_o(rd_data), .prog_valid_i(prog_valid), .prog_ready_o(prog_ready),
    .prog_commit_i(prog_commit), .erase_req_i(erase_req), .op_done_o(op_done));
  // Record accepted program words and erase requests
  always @(posedge sys_clk) begin
    if (prog_valid && prog_ready) begin
      if (push_n == 0) begin
        first_addr <= prog_addr;
        first_data <= prog_data;
      end
      push_n <= push_n + 1;
    end
    if (erase_req) begin
      er_n <= er_n + 1;
      er_kind <= erase_kind;
      er_addr <= erase_addr;
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One byte, bit set at the fall, taken at the rise; sampled mid-cycle
  task automatic xb(input logic [7:0] tx);
    for (int i = 7; i >= 0; i--) begin
      sck <= 1'b0;
      sdi <= tx[i];
      cyc(7);
      @(negedge sys_clk);
      rx = {rx[6:0], so};
      dl = {dl[13:0], sio_o, so};
      @(posedge sys_clk);
      sck <= 1'b1;
      cyc(8);
    end
  endtask
  task automatic go(input logic [7:0] op, input bit wa, input logic [23:0] a);
    sck <= idle_hi;
    cs_n <= 1'b0;
    cyc(8);
    xb(op);
    if (wa) begin
      xb(a[23:16]);
      xb(a[15:8]);
      xb(a[7:0]);
    end
  endtask
  task automatic stop;
    cyc(8);
    sck <= idle_hi;
    cyc(8);
    cs_n <= 1'b1;
    cyc(16);
  endtask
  task automatic wait_ready;
    for (int i = 0; i < 3000 && status[0] !== 1'b0; i++) cyc(1);
    chk(status[0], 1'b0);
  endtask
  task automatic wr_status(input logic [7:0] v);
    go(8'h06, 0, 0);
    stop;
    go(8'h01, 0, 0);
    xb(v);
    stop;
  endtask
  task automatic prog(input bit set_write_enable_cmd, input logic [23:0] a, input int exp);
    if (set_write_enable_cmd) begin
      go(8'h06, 0, 0);
      stop;
    end
    push_n <= 0;
    go(8'h02, 1, a);
    xb(8'h5c);
    stop;
    wait_ready;
    chk(push_n, exp);
    chk(overrun, 1'b0);
  endtask
  task automatic t_read(input logic m, input logic [23:0] a);
    idle_hi <= m;
    cyc(4);
    go(8'h03, 1, a);
    xb(8'h00);
    chk(rx, a[7:0] ^ 8'ha5);
    pause_n <= 1'b0;
    cyc(8);
    chk(so_oe, 1'b0);
    xb(8'hff);
    pause_n <= 1'b1;
    cyc(8);
    xb(8'h00);
    chk(rx, 8'((a[7:0] + 8'h01) ^ 8'ha5));
    chk(so_oe, 1'b1);
    stop;
    chk({so_oe, standby}, 2'b01);
    xb(8'h06);
    sck <= idle_hi;
    cyc(16);
    chk({so_oe, status[1]}, 2'b00);
  endtask
  task automatic t_dual;
    go(8'h3b, 1, 24'h000010);
    xb(8'h00);
    xb(8'h00);
    chk(dl, 16'hb5b4);
    chk(sio_oe, 1'b1);
    stop;
  endtask
  task automatic t_fill;
    go(8'h06, 0, 0);
    stop;
    chk(status[1], 1'b1);
    stall <= 1'b1;
    push_n <= 0;
    go(8'h02, 1, 24'h07ff00);
    xb(8'ha1);
    xb(8'hb2);
    xb(8'hc3);
    chk(overrun, 1'b1);
    stall <= 1'b0;
    stop;
    wait_ready;
    chk({push_n, first_addr, first_data}, {32'd2, 19'h7ff00, 8'ha1});
    chk(status[1:0], 2'b00);
  endtask
  task automatic t_protect;
    wr_status(8'h04);
    go(8'h05, 0, 0);
    xb(8'h00);
    stop;
    chk({rx, status}, 16'h0404);
    wp_n <= 1'b0;
    prog(1, 24'h07ff10, 0);
    prog(1, 24'h000010, 1);
    er_n <= 0;
    go(8'h06, 0, 0);
    stop;
    go(8'hc7, 0, 0);
    stop;
    chk(er_n, 0);
    wp_n <= 1'b1;
    prog(1, 24'h07ff10, 1);
    prog(0, 24'h000020, 0);
  endtask
  task automatic t_lock;
    logic [7:0] ops [3] = '{8'hc7, 8'h20, 8'hd8};
    logic [23:0] ad [3] = '{24'h0, 24'h012000, 24'h030000};
    wr_status(8'h80);
    wp_n <= 1'b0;
    wr_status(8'h04);
    chk(status[7:2], 6'h20);
    for (int i = 0; i < 3; i++) begin
      er_n <= 0;
      go(8'h06, 0, 0);
      stop;
      go(ops[i], i > 0, ad[i]);
      stop;
      wait_ready;
      chk({er_n, er_kind}, {32'd1, 2'(i == 0 ? 2 : i - 1)});
      if (i > 0) chk(er_addr[18:12], ad[i][18:12]);
    end
  endtask
  task automatic report_and_stop;
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    cyc(8);
    reset <= 1'b0;
    cyc(4);
    chk({standby, status, so_oe, sio_oe}, 11'h400);
    t_read(1'b0, 24'h051234);
    t_read(1'b1, 24'h0700ff);
    t_dual;
    t_fill;
    t_protect;
    t_lock;
    report_and_stop;
  end
  // Watchdog against a hang
  initial begin
    cyc(60000);
    bad_count++;
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
